// [rtl/lkp_pkg.sv]
// constants, carriers and types for the lcd key-scan pin control block
package lkp_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int STROBE_TIME_NS = 1000000;
    localparam int STROBE_CYCLES  = STROBE_TIME_NS / CLK_PERIOD_NS;
    localparam int COM_TIME_NS    = 51200;
    localparam int COM_CYCLES     = COM_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W          = 24;

    // pin counts
    localparam int N_STROBE     = 8;
    localparam int N_SENSE      = 4;
    localparam int N_SINK       = 3;
    localparam int N_GEN        = 3;
    localparam int N_COM        = 32;
    localparam int N_ICON       = 2;
    localparam int N_SEG        = 60;
    localparam int COM_PER_LINE = 8;
    localparam int N_SLOT       = N_COM + N_ICON;
    localparam int SLOT_W       = 6;
    localparam int IDX_W        = 3;

    // host port select strap levels
    localparam logic MODE_I2C = 1'b0;
    localparam logic MODE_SER = 1'b1;

    // serial framing
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam int         CMD_RD_POS = 7;
    localparam int         SINK_LSB   = 0;
    localparam int         GEN_LSB    = 3;
    // upper five bits of the bus identification code, value is arbitrary
    localparam logic [4:0] I2C_ADDR_BASE = 5'h0a;

    // strobe pattern for slot zero
    localparam logic [N_STROBE-1:0] STB_FIRST = 8'h01;

    // drive level of one common output
    typedef enum logic [1:0] {
        LKP_LVL_DESEL,
        LKP_LVL_SEL,
        LKP_LVL_VCC
    } lkp_level_e;

    typedef lkp_level_e [N_COM-1:0]  lkp_com_t;
    typedef lkp_level_e [N_ICON-1:0] lkp_icon_t;

    // display control bits
    typedef struct packed {
        logic       sleep_ctrl_bit;
        logic       standby_ctrl_bit;
        logic       common_order_reverse;
        logic       segment_order_reverse;
        logic [1:0] lines_used_m1;
    } lkp_disp_s;

    // key-scan result as read by the host
    typedef struct packed {
        logic                  valid;
        logic [IDX_W-1:0]      strobe;
        logic [N_SENSE-1:0]    sense;
    } lkp_key_s;

endpackage

// [rtl/lkp_pin_ctrl.sv]
// lcd key-scan controller pin logic: host port, key scan, ports, commons
`timescale 1ns/1ps
`default_nettype none

module lkp_pin_ctrl #(
    parameter int STROBE_CYC = lkp_pkg::STROBE_CYCLES, // cycles per strobe
    parameter int COM_CYC    = lkp_pkg::COM_CYCLES     // cycles per common
) (
    input  wire logic                          clk_sys,    // system clock
    input  wire logic                          rst,        // reset, sync on clk_sys, async on the link side
    input  wire logic                          serial_clk, // host clock
    input  wire logic                          host_port_select, // strap
    input  wire logic                          ident_bit1_or_select_n, // pin
    input  wire logic                          ident_bit0_strap, // strap
    input  wire logic                          sda_in,     // data line in
    output logic                               sda_out,    // data line out
    output logic                               sda_oe,     // data drive
    output logic                               irq_n,      // key interrupt
    output logic [lkp_pkg::N_STROBE-1:0]       key_strobe_out, // strobes
    input  wire logic [lkp_pkg::N_SENSE-1:0]   key_sense_in, // sense lines
    output logic [lkp_pkg::N_SINK-1:0]         sink_drive_port, // led ports
    output logic [lkp_pkg::N_GEN-1:0]          general_out_port, // ports
    input  wire lkp_pkg::lkp_disp_s            disp_ctrl,  // display bits
    input  wire logic [lkp_pkg::N_SEG-1:0]     seg_data_in, // segment data
    output logic [lkp_pkg::N_SEG-1:0]          segment_out, // segment pins
    output lkp_pkg::lkp_com_t                  char_common_out, // commons
    output lkp_pkg::lkp_icon_t                 icon_common_out  // icon coms
);
    import lkp_pkg::*;

    // state on the system clock
    typedef struct packed {
        logic                mode_m;
        logic                mode_s;
        logic                id1_m;
        logic                id1_s;
        logic                id0_m;
        logic                id0_s;
        logic [N_SENSE-1:0]  sense_m;
        logic [N_SENSE-1:0]  sense_s;
        logic                wr_m;
        logic                wr_s;
        logic                wr_d;
        logic                rd_m;
        logic                rd_s;
        logic                rd_d;
        logic [TMR_W-1:0]    stb_tmr;
        logic [IDX_W-1:0]    stb_idx;
        logic [N_STROBE-1:0] strobe;
        lkp_key_s            key;
        logic                irq_n;
        logic [N_SINK-1:0]   sink;
        logic [N_GEN-1:0]    gen;
        logic [TMR_W-1:0]    com_tmr;
        logic [SLOT_W-1:0]   slot;
        lkp_com_t            com;
        lkp_icon_t           icon;
        logic [N_SEG-1:0]    seg;
    } lkp_sys_s;

    // state on the host serial clock
    typedef struct packed {
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic       addressed;
        logic       tx_pend;
        logic       tx_act;
        logic [7:0] tx_sh;
        logic       ack;
        logic       sda_out;
        logic       sda_oe;
        logic [7:0] wr_data;
        logic       wr_tog;
        logic       rd_tog;
    } lkp_lnk_s;

    lkp_sys_s          s_r;
    lkp_sys_s          s_nxt;
    lkp_lnk_s          l_r;
    lkp_lnk_s          l_nxt;
    logic              wr_evt;
    logic              rd_evt;
    logic              stb_tick;
    logic              com_tick;
    logic              key_hit;
    logic              serial;
    logic              desel;
    logic [7:0]        byte_in;
    logic [6:0]        own_addr;
    logic [SLOT_W-1:0] lg;

    // events and decodes for the two processes, none used by both, serial only by the link side
    assign wr_evt   = s_r.wr_s ^ s_r.wr_d;
    assign rd_evt   = s_r.rd_s ^ s_r.rd_d;
    assign stb_tick = s_r.stb_tmr == TMR_W'(STROBE_CYC - 1);
    assign com_tick = s_r.com_tmr == TMR_W'(COM_CYC - 1);
    assign key_hit  = stb_tick && (|s_r.sense_s);
    assign serial   = s_r.mode_s == MODE_SER;
    assign desel    = serial && ident_bit1_or_select_n;
    assign byte_in  = {l_r.sh[6:0], sda_in};
    assign own_addr = {I2C_ADDR_BASE, s_r.id1_s, s_r.id0_s};

    // system clock next state: syncs, key scan, ports, commons
    always_comb begin
        s_nxt = s_r;
        lg    = '0;
        s_nxt.mode_m  = host_port_select;
        s_nxt.mode_s  = s_r.mode_m;
        s_nxt.id1_m   = ident_bit1_or_select_n;
        s_nxt.id1_s   = s_r.id1_m;
        s_nxt.id0_m   = ident_bit0_strap;
        s_nxt.id0_s   = s_r.id0_m;
        s_nxt.sense_m = key_sense_in;
        s_nxt.sense_s = s_r.sense_m;
        s_nxt.wr_m    = l_r.wr_tog;
        s_nxt.wr_s    = s_r.wr_m;
        s_nxt.wr_d    = s_r.wr_s;
        s_nxt.rd_m    = l_r.rd_tog;
        s_nxt.rd_s    = s_r.rd_m;
        s_nxt.rd_d    = s_r.rd_s;
        // port write from the host, word held stable by the link side
        if (wr_evt) begin
            s_nxt.sink = l_r.wr_data[SINK_LSB +: N_SINK];
            s_nxt.gen  = l_r.wr_data[GEN_LSB +: N_GEN];
        end
        // host read releases the interrupt
        if (rd_evt) begin
            s_nxt.irq_n = 1'b1;
        end
        // a new key wins over a release in the same cycle
        if (key_hit && (s_r.irq_n || rd_evt)) begin
            s_nxt.key.valid  = 1'b1;
            s_nxt.key.strobe = s_r.stb_idx;
            s_nxt.key.sense  = s_r.sense_s;
            s_nxt.irq_n      = 1'b0;
        end
        // strobe stepping at a fixed interval
        if (stb_tick) begin
            s_nxt.stb_tmr = '0;
            s_nxt.stb_idx = s_r.stb_idx + 1'b1;
            s_nxt.strobe  = STB_FIRST << s_nxt.stb_idx;
        end else begin
            s_nxt.stb_tmr = s_r.stb_tmr + 1'b1;
        end
        // common slot stepping, icon commons after the character commons
        if (com_tick) begin
            s_nxt.com_tmr = '0;
            s_nxt.slot    = (s_r.slot == SLOT_W'(N_SLOT - 1)) ? '0
                                : s_r.slot + 1'b1;
        end else begin
            s_nxt.com_tmr = s_r.com_tmr + 1'b1;
        end
        // character commons with mirroring, unused lines and sleep
        for (int i = 0; i < N_COM; i++) begin
            lg = disp_ctrl.common_order_reverse ? SLOT_W'(N_COM - 1 - i)
                                                 : SLOT_W'(i);
            if (disp_ctrl.sleep_ctrl_bit || disp_ctrl.standby_ctrl_bit) begin
                s_nxt.com[i] = LKP_LVL_VCC;
            end else if ((lg / SLOT_W'(COM_PER_LINE))
                         > SLOT_W'(disp_ctrl.lines_used_m1)) begin
                s_nxt.com[i] = LKP_LVL_DESEL;
            end else if (s_nxt.slot == lg) begin
                s_nxt.com[i] = LKP_LVL_SEL;
            end else begin
                s_nxt.com[i] = LKP_LVL_DESEL;
            end
        end
        // icon commons on their own slots
        for (int j = 0; j < N_ICON; j++) begin
            if (disp_ctrl.sleep_ctrl_bit || disp_ctrl.standby_ctrl_bit) begin
                s_nxt.icon[j] = LKP_LVL_VCC;
            end else if (s_nxt.slot == SLOT_W'(N_COM + j)) begin
                s_nxt.icon[j] = LKP_LVL_SEL;
            end else begin
                s_nxt.icon[j] = LKP_LVL_DESEL;
            end
        end
        // segment pin order
        for (int k = 0; k < N_SEG; k++) begin
            s_nxt.seg[k] = disp_ctrl.segment_order_reverse
                               ? seg_data_in[N_SEG - 1 - k]
                               : seg_data_in[k];
        end
    end

    // system clock register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r        <= '0;
            s_r.irq_n  <= 1'b1;
            s_r.strobe <= STB_FIRST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // serial clock next state: framing, address, commands, read out
    always_comb begin
        l_nxt = l_r;
        if (desel) begin
            l_nxt.bit_cnt = BIT_FIRST;
            l_nxt.tx_act  = 1'b0;
            l_nxt.tx_pend = 1'b0;
            l_nxt.ack     = 1'b0;
        end else begin
            if (l_r.bit_cnt <= BIT_LAST) begin
                l_nxt.sh = byte_in;
            end
            if (l_r.bit_cnt == BIT_LAST) begin
                l_nxt.bit_cnt = serial ? BIT_FIRST : BIT_ACK;
                if (l_r.tx_act) begin
                    l_nxt.tx_act = 1'b0;
                end else if (!serial && !l_r.addressed) begin
                    if (byte_in[7:1] == own_addr) begin
                        l_nxt.addressed = 1'b1;
                        l_nxt.ack       = 1'b1;
                    end
                end else begin
                    l_nxt.ack = !serial;
                    if (byte_in[CMD_RD_POS]) begin
                        l_nxt.tx_pend = 1'b1;
                    end else begin
                        l_nxt.wr_data = byte_in;
                        l_nxt.wr_tog  = !l_r.wr_tog;
                    end
                end
            end else if (l_r.bit_cnt == BIT_ACK) begin
                l_nxt.bit_cnt = BIT_FIRST;
                l_nxt.ack     = 1'b0;
            end else begin
                l_nxt.bit_cnt = l_r.bit_cnt + 1'b1;
                if (l_r.tx_act) begin
                    l_nxt.tx_sh = {l_r.tx_sh[6:0], 1'b0};
                end
            end
            // read data loads at the start of the next byte
            if (l_nxt.tx_pend && l_nxt.bit_cnt == BIT_FIRST) begin
                l_nxt.tx_pend = 1'b0;
                l_nxt.tx_act  = 1'b1;
                l_nxt.tx_sh   = s_r.key;
                l_nxt.rd_tog  = !l_r.rd_tog;
            end
        end
        // drive only while sending, open drain in i2c mode
        l_nxt.sda_out = l_nxt.ack ? 1'b0 : l_nxt.tx_sh[7];
        l_nxt.sda_oe  = (l_nxt.ack || (l_nxt.tx_act &&
                         l_nxt.bit_cnt <= BIT_LAST)) &&
                        (serial || !l_nxt.sda_out);
    end

    // serial clock register, cleared while the clock stands still
    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // outputs straight from flip-flops
    assign sda_out          = l_r.sda_out;
    assign sda_oe           = l_r.sda_oe;
    assign irq_n            = s_r.irq_n;
    assign key_strobe_out   = s_r.strobe;
    assign sink_drive_port  = s_r.sink;
    assign general_out_port = s_r.gen;
    assign segment_out      = s_r.seg;
    assign char_common_out  = s_r.com;
    assign icon_common_out  = s_r.icon;

    // serial read command seen on the last data bit
    sequence s_read_cmd;
        serial && !desel && l_r.bit_cnt == BIT_LAST && !l_r.tx_act &&
            byte_in[CMD_RD_POS];
    endsequence

    // device then drives the line for the following byte
    sequence s_read_out;
        l_r.tx_act && l_r.sda_oe;
    endsequence

    a_read_drive: assert property (@(posedge serial_clk)
        disable iff (rst)
        s_read_cmd |=> s_read_out [*8] ##1 !l_r.sda_oe)
        else $error("read byte not driven for eight clocks");

    a_cs_idle: assert property (@(posedge serial_clk)
        disable iff (rst)
        desel |=> l_r.bit_cnt == BIT_FIRST && !l_r.sda_oe)
        else $error("deselect did not clear serial framing");

    a_ser_frame: assert property (@(posedge serial_clk)
        disable iff (rst)
        serial && !desel && l_r.bit_cnt == BIT_LAST
            |=> l_r.bit_cnt == BIT_FIRST)
        else $error("serial byte not eight bits");

    a_ack_drive: assert property (@(posedge serial_clk)
        disable iff (rst)
        !serial && l_r.bit_cnt == BIT_LAST && !l_r.tx_act &&
            byte_in[7:1] == own_addr
            |=> l_r.sda_oe && !l_r.sda_out ##1 !l_r.ack)
        else $error("address match not acknowledged");

    a_irq_hold: assert property (@(posedge clk_sys)
        disable iff (rst)
        !irq_n && !rd_evt |=> !irq_n)
        else $error("interrupt released without read");

    a_irq_set: assert property (@(posedge clk_sys)
        disable iff (rst)
        key_hit && irq_n |=> !irq_n && s_r.key.sense == $past(s_r.sense_s)
            && s_r.key.strobe == $past(s_r.stb_idx))
        else $error("key not latched with its strobe");

    a_strobe_onehot: assert property (@(posedge clk_sys)
        disable iff (rst)
        $onehot(key_strobe_out) and
            ($changed(key_strobe_out) |-> $past(stb_tick)))
        else $error("strobe not one-hot or stepped early");

    a_sleep_vcc: assert property (@(posedge clk_sys)
        disable iff (rst)
        disp_ctrl.sleep_ctrl_bit || disp_ctrl.standby_ctrl_bit
            |=> char_common_out[0] == LKP_LVL_VCC &&
                char_common_out[N_COM-1] == LKP_LVL_VCC)
        else $error("commons not at supply in sleep");

    a_unused_desel: assert property (@(posedge clk_sys)
        disable iff (rst)
        disp_ctrl.lines_used_m1 == 2'h0 && !disp_ctrl.sleep_ctrl_bit &&
            !disp_ctrl.standby_ctrl_bit && !disp_ctrl.common_order_reverse
            |=> char_common_out[N_COM-1:COM_PER_LINE] ==
                {(N_COM-COM_PER_LINE){LKP_LVL_DESEL}})
        else $error("unused common not deselected");

    a_port_write: assert property (@(posedge clk_sys)
        disable iff (rst)
        wr_evt |=> sink_drive_port == $past(l_r.wr_data[SINK_LSB +: N_SINK])
            && general_out_port == $past(l_r.wr_data[GEN_LSB +: N_GEN]))
        else $error("port write not applied");

endmodule
`default_nettype wire

// [testbench/lkp_host_model.sv]
// host-side model: serial clock, select and the shared data line
`timescale 1ns/1ps
`default_nettype none
module lkp_host_model #(
    parameter int HALF_NS = 24 // half of the 48 ns link period
) (
    input  wire logic i2c_mode,   // line has a pull-up in i2c mode
    input  wire logic dut_out,    // device data drive value
    input  wire logic dut_oe,     // device drives the line
    output logic      serial_clk, // link clock, low outside frames
    output logic      select_n,   // serial mode select
    output logic      sda_line    // resolved data line level
);
    logic h_bit;
    logic h_oe;
    logic last;

    // idle: clock low, deselected, line released
    initial begin
        serial_clk = 1'b0;
        select_n   = 1'b1;
        h_bit      = 1'b1;
        h_oe       = 1'b0;
        last       = 1'b0;
    end

    // remember the last driven level so a floating line reads its inverse
    always @(dut_oe, dut_out, h_oe, h_bit) begin
        if (dut_oe)
            last = dut_out;
        else if (h_oe)
            last = h_bit;
    end

    // open drain with pull-up in i2c, floating inverse otherwise
    assign sda_line = i2c_mode ? ~((dut_oe & ~dut_out) | (h_oe & ~h_bit))
                    : (dut_oe ? dut_out : (h_oe ? h_bit : ~last));

    // change the select while the clock stands low
    task automatic sel(input logic s_n);
        #(HALF_NS);
        select_n = s_n;
        #(HALF_NS);
    endtask

    // clock n bits msb first; drive low leaves the line to the device
    task automatic shift(input logic [7:0] tx, input int n,
                         input logic drive, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            h_oe  = drive;
            h_bit = tx[i];
            #(HALF_NS);
            rx[i]      = sda_line;
            serial_clk = 1'b1;
            #2;
            if (i == 8 - n)
                h_oe = 1'b0;
            #(HALF_NS - 2);
            serial_clk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the lcd key-scan pin control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lkp_pkg::*;
    localparam int SCYC = 16;
    localparam int CCYC = 4;
    logic                clk_sys, rst, mode, id1, id0, ident_pin;
    logic                sda_out, sda_oe, irq_n, sclk, sel_n, sda_line;
    logic [N_SENSE-1:0]  sense;
    logic [N_STROBE-1:0] strobe;
    logic [N_SINK-1:0]   sink;
    logic [N_GEN-1:0]    gen;
    logic [N_SEG-1:0]    seg_in, seg_out;
    lkp_disp_s           disp;
    lkp_com_t            coms;
    lkp_icon_t           icons;
    logic [7:0]          rx;
    int                  err_count, check_count;

    // shared pin: select in serial mode, strap in i2c mode
    assign ident_pin = mode ? sel_n : id1;

    lkp_pin_ctrl #(.STROBE_CYC(SCYC), .COM_CYC(CCYC)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .serial_clk(sclk),
        .host_port_select(mode), .ident_bit1_or_select_n(ident_pin),
        .ident_bit0_strap(id0), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .irq_n(irq_n), .key_strobe_out(strobe),
        .key_sense_in(sense), .sink_drive_port(sink),
        .general_out_port(gen), .disp_ctrl(disp), .seg_data_in(seg_in),
        .segment_out(seg_out), .char_common_out(coms),
        .icon_common_out(icons));

    lkp_host_model host_u (
        .i2c_mode(~mode), .dut_out(sda_out), .dut_oe(sda_oe),
        .serial_clk(sclk), .select_n(sel_n), .sda_line(sda_line));

    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // count and report one comparison
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // reset with the given straps, then let the syncs settle
    task automatic do_reset(input logic m, input logic b1, input logic b0);
        @(posedge clk_sys);
        rst  <= 1'b1;
        mode <= m;
        id1  <= b1;
        id0  <= b0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask

    // one selected serial write byte, then wait for the ports
    task automatic wr(input logic [7:0] b);
        host_u.sel(1'b0);
        host_u.shift(b, 8, 1'b1, rx);
        host_u.sel(1'b1);
        repeat (8) @(posedge clk_sys);
    endtask

    // port writes at the all-ones value and a mixed one
    task automatic t_ports();
        wr(8'h3f);
        check(sink, 3'h7);
        check(gen, 3'h7);
        wr(8'h15);
        check({gen, sink}, 6'h15);
    endtask

    // deselected traffic ignored, partial byte dropped
    task automatic t_deselect();
        host_u.shift(8'h07, 8, 1'b1, rx);
        repeat (8) @(posedge clk_sys);
        check({gen, sink}, 6'h15);
        host_u.sel(1'b0);
        host_u.shift(8'h3f, 4, 1'b1, rx);
        host_u.sel(1'b1);
        host_u.shift(8'h00, 1, 1'b1, rx);
        wr(8'h2a);
        check({gen, sink}, 6'h2a);
    endtask

    // one-hot strobe rotates with fixed spacing, through the wrap
    task automatic t_strobe();
        logic [7:0] prev;
        int         n;
        @(negedge clk_sys);
        prev = strobe;
        for (int k = 0; k < 10; k++) begin
            n = 0;
            while (strobe === prev && n < 40) begin
                @(negedge clk_sys);
                n++;
            end
            if (k > 0)
                check(n, SCYC);
            check(strobe, {prev[6:0], prev[7]});
            prev = strobe;
        end
    endtask

    // key on strobe 2, interrupt held until the host reads it
    task automatic t_key();
        int n;
        n = 0;
        while (strobe !== 8'h04 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        sense <= 4'h5;
        while (strobe === 8'h04)
            @(negedge clk_sys);
        @(posedge clk_sys);
        sense <= 4'h0;
        n = 0;
        while (irq_n !== 1'b0 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        repeat (30) @(posedge clk_sys);
        check(irq_n, 1'b0);
        host_u.sel(1'b0);
        host_u.shift(8'h80, 8, 1'b1, rx);
        host_u.shift(8'h00, 8, 1'b0, rx);
        host_u.sel(1'b1);
        check(rx, 8'ha5);
        repeat (8) @(posedge clk_sys);
        check(irq_n, 1'b1);
    endtask

    // watch two full common rounds under one display setting
    task automatic t_coms(input lkp_disp_s d, input logic [31:0] allow);
        logic [31:0] seen;
        logic [31:0] bad;
        logic [1:0]  iseen;
        logic        vcc;
        seen  = 32'h0;
        bad   = 32'h0;
        iseen = 2'h0;
        vcc   = d.sleep_ctrl_bit | d.standby_ctrl_bit;
        @(posedge clk_sys);
        disp <= d;
        seg_in <= d.segment_order_reverse ? 60'h5 : 60'h3;
        repeat (4) @(posedge clk_sys);
        repeat (34 * CCYC * 2) begin
            @(negedge clk_sys);
            for (int i = 0; i < N_COM; i++) begin
                if (coms[i] === LKP_LVL_SEL)
                    seen[i] = 1'b1;
                if (vcc ? coms[i] !== LKP_LVL_VCC : coms[i] === LKP_LVL_VCC)
                    bad[i] = 1'b1;
            end
            for (int j = 0; j < N_ICON; j++)
                if (icons[j] === LKP_LVL_SEL)
                    iseen[j] = 1'b1;
        end
        check(bad, 32'h0);
        check(seen, vcc ? 32'h0 : allow);
        if (!vcc) begin
            check(iseen, 2'h3);
            check(seg_out, d.segment_order_reverse ?
                  60'ha00000000000000 : 60'h3);
        end
    endtask

    // one i2c frame: eight bits then the acknowledge clock
    task automatic i2c_frame(input logic [7:0] b, input logic ack);
        host_u.shift(b, 8, 1'b1, rx);
        host_u.shift(8'hff, 1, 1'b0, rx);
        check(rx[7], ack);
    endtask

    // matching and mismatching identification codes
    task automatic t_i2c();
        do_reset(1'b0, 1'b1, 1'b0);
        i2c_frame(8'h54, 1'b0);
        i2c_frame(8'h1d, 1'b0);
        repeat (8) @(posedge clk_sys);
        check({gen, sink}, 6'h1d);
        do_reset(1'b0, 1'b0, 1'b0);
        i2c_frame(8'h54, 1'b1);
        i2c_frame(8'h3f, 1'b1);
        repeat (8) @(posedge clk_sys);
        check({gen, sink}, 6'h00);
        do_reset(1'b0, 1'b1, 1'b1);
        i2c_frame(8'h54, 1'b1);
        i2c_frame(8'h56, 1'b0);
        i2c_frame(8'h2a, 1'b0);
        repeat (8) @(posedge clk_sys);
        check({gen, sink}, 6'h2a);
    endtask

    // main sequence
    initial begin
        rst        <= 1'b1; // a real rising edge clears the link side
        mode        = 1'b1;
        id1         = 1'b1;
        id0         = 1'b0;
        sense       = 4'h0;
        disp        = '0;
        seg_in      = 60'h3;
        err_count   = 0;
        check_count = 0;
        do_reset(1'b1, 1'b1, 1'b0);
        t_ports();
        t_deselect();
        t_strobe();
        t_key();
        t_coms(lkp_disp_s'{1'b0, 1'b0, 1'b0, 1'b0, 2'd3}, 32'hffffffff);
        t_coms(lkp_disp_s'{1'b0, 1'b0, 1'b0, 1'b0, 2'd0}, 32'h000000ff);
        t_coms(lkp_disp_s'{1'b0, 1'b0, 1'b1, 1'b1, 2'd0}, 32'hff000000);
        t_coms(lkp_disp_s'{1'b0, 1'b0, 1'b1, 1'b0, 2'd1}, 32'hffff0000);
        t_coms(lkp_disp_s'{1'b1, 1'b0, 1'b0, 1'b0, 2'd3}, 32'h0);
        t_coms(lkp_disp_s'{1'b0, 1'b1, 1'b1, 1'b0, 2'd3}, 32'h0);
        t_i2c();
        tally_and_finish();
    end

    // cut a hang short well past the expected run time
    initial begin
        #(40000 * 50);
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
